// File: branch_bit_shift_exec.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module branch_bit_shift_exec #(
	parameter int PC_W = 16,
	parameter int IO_COUNT = 32
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Architectural state seen by the rest of the core.
	output logic [PC_W-1:0] pc_o,
	output logic [7:0] status_flags_o,
	output logic [7:0] work_reg_o,
	output logic busy_o
);

	// Bus answer state.
	logic ack;
	logic [31:0] rdata;
	logic next_ack;
	logic [31:0] next_rdata;

	// Architectural state.
	logic [PC_W-1:0] pc;
	logic [7:0] flags;
	logic [7:0] wreg;
	logic [20:0] instr;
	logic [7:0] io_regs [IO_COUNT];
	logic [PC_W-1:0] next_pc;
	logic [7:0] next_flags;
	logic [7:0] next_wreg;
	logic [20:0] next_instr;
	logic [7:0] next_io_regs [IO_COUNT];

	// Sequencer state.
	exec_pkg::state_t state;
	exec_pkg::state_t next_state;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic last_taken;
	logic next_last_taken;
	logic [1:0] last_cycles;
	logic [1:0] next_last_cycles;
	logic busy;
	logic next_busy;

	// Decoded instruction and computed results.
	exec_pkg::op_t op;
	logic [2:0] sel;
	logic [6:0] k;
	logic [4:0] p_idx;
	logic two_word;
	logic io_bit;
	logic take;
	logic [1:0] cycles;
	logic [PC_W-1:0] target_pc;
	logic [7:0] shift_value;
	logic [7:0] shift_flags;
	logic req;
	logic [5:0] word_idx;

	// True for every conditional relative branch.
	function automatic logic is_branch(input exec_pkg::op_t o);
		is_branch = (o >= exec_pkg::OP_BRANCH_FLAG_SET) && (o <= exec_pkg::OP_BRANCH_IRQ_DISABLED);
	endfunction

	// True for the two skip-on-I/O-bit tests.
	function automatic logic is_skip(input exec_pkg::op_t o);
		is_skip = (o == exec_pkg::OP_SKIP_IO_BIT_ONE) || (o == exec_pkg::OP_SKIP_IO_BIT_ZERO);
	endfunction

	// Number of cycles an operation occupies, given its outcome.
	function automatic logic [1:0] cycles_of(input exec_pkg::op_t o, input logic t, input logic tw);
		if (is_branch(o)) begin
			cycles_of = t ? exec_pkg::CYC_BRANCH_TAKEN : exec_pkg::CYC_BRANCH_NOT;
		end else if (is_skip(o)) begin
			if (!t) begin
				cycles_of = exec_pkg::CYC_SKIP_NONE;
			end else begin
				cycles_of = tw ? exec_pkg::CYC_SKIP_TWO : exec_pkg::CYC_SKIP_ONE;
			end
		end else if (o == exec_pkg::OP_IO_BIT_SET || o == exec_pkg::OP_IO_BIT_CLEAR) begin
			cycles_of = exec_pkg::CYC_IO_BIT;
		end else begin
			cycles_of = exec_pkg::CYC_SHIFT;
		end
	endfunction

	// Merges write data into a register under the byte selects.
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		merge_sel = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge_sel[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	// Field extraction from the instruction register.
	assign op = exec_pkg::op_t'(instr[exec_pkg::INSTR_OP_LSB +: 5]);
	assign sel = instr[exec_pkg::INSTR_SEL_LSB +: 3];
	assign k = instr[exec_pkg::INSTR_K_LSB +: exec_pkg::INSTR_K_W];
	assign p_idx = instr[exec_pkg::INSTR_P_LSB +: 5];
	assign two_word = instr[exec_pkg::INSTR_TWO_BIT];
	assign io_bit = (int'(p_idx) < IO_COUNT) ? io_regs[p_idx][sel] : 1'b0;
	assign req = wb_cyc_i & wb_stb_i & ~ack;
	assign word_idx = wb_adr_i[7:2];

	branch_cond_eval u_cond (
		.op_i(op),
		.sel_i(sel),
		.flags_i(flags),
		.io_bit_i(io_bit),
		.take_o(take)
	);

	shift_unit u_shift (
		.op_i(op),
		.value_i(wreg),
		.flags_i(flags),
		.value_o(shift_value),
		.flags_o(shift_flags)
	);

	assign cycles = cycles_of(op, take, two_word); // RULE_02

	// New program counter: relative target, skip distance or plain step.
	always_comb begin
		if (is_branch(op) && take) begin
			target_pc = pc + {{(PC_W-7){k[6]}}, k} + PC_W'(1); // RULE_01
		end else if (is_skip(op) && take) begin
			target_pc = two_word ? pc + PC_W'(3) : pc + PC_W'(2); // RULE_12
		end else begin
			target_pc = pc + PC_W'(1);
		end
	end

	// Bus answer: one ack per request, read data registered beside it.
	always_comb begin
		next_ack = req;
		next_rdata = 32'h0000_0000;
		if (req && !wb_we_i) begin
			if (wb_adr_i >= exec_pkg::OFF_IO_BASE) begin
				if (int'(word_idx) - 32 < IO_COUNT) begin
					next_rdata = {24'h00_0000, io_regs[word_idx[4:0]]};
				end
			end else begin
				case ({wb_adr_i[7:2], 2'b00})
					exec_pkg::OFF_INSTR: next_rdata = {11'h000, instr};
					exec_pkg::OFF_PC: next_rdata = 32'(pc);
					exec_pkg::OFF_FLAGS: next_rdata = {24'h00_0000, flags};
					exec_pkg::OFF_WREG: next_rdata = {24'h00_0000, wreg};
					exec_pkg::OFF_STATUS: next_rdata = {28'h000_0000, last_cycles, last_taken, busy};
					default: next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// Sequencer: an instruction write starts a run lasting its cycle count.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_last_taken = last_taken;
		next_last_cycles = last_cycles;
		next_busy = busy;
		case (state)
			exec_pkg::ST_IDLE: begin
				if (req && wb_we_i && wb_sel_i[0] &&
					{wb_adr_i[7:2], 2'b00} == exec_pkg::OFF_INSTR) begin
					next_state = exec_pkg::ST_RUN;
					next_cnt = 2'h0;
					next_busy = 1'b1;
				end
			end
			exec_pkg::ST_RUN: begin
				next_cnt = cnt + 2'h1;
				if (cnt == cycles - 2'h1) begin
					next_state = exec_pkg::ST_IDLE;
					next_busy = 1'b0;
					next_last_taken = take;
					next_last_cycles = cycles;
				end
			end
			default: begin
				next_state = exec_pkg::ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= exec_pkg::ST_IDLE;
			cnt <= 2'h0;
			last_taken <= 1'b0;
			last_cycles <= 2'h0;
			busy <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			last_taken <= next_last_taken;
			last_cycles <= next_last_cycles;
			busy <= next_busy;
		end
	end

	// Architectural state: software writes while idle, results commit at run end.
	always_comb begin
		logic [31:0] merged;
		merged = 32'h0000_0000;
		next_pc = pc;
		next_flags = flags;
		next_wreg = wreg;
		next_instr = instr;
		next_io_regs = io_regs;
		if (state == exec_pkg::ST_IDLE && req && wb_we_i) begin
			if (wb_adr_i >= exec_pkg::OFF_IO_BASE) begin
				if (int'(word_idx) - 32 < IO_COUNT && wb_sel_i[0]) begin
					next_io_regs[word_idx[4:0]] = wb_dat_i[7:0];
				end
			end else begin
				case ({wb_adr_i[7:2], 2'b00})
					exec_pkg::OFF_INSTR: begin
						merged = merge_sel({11'h000, instr}, wb_dat_i, wb_sel_i);
						next_instr = merged[20:0];
					end
					exec_pkg::OFF_PC: begin
						merged = merge_sel(32'(pc), wb_dat_i, wb_sel_i);
						next_pc = merged[PC_W-1:0];
					end
					exec_pkg::OFF_FLAGS: next_flags = wb_sel_i[0] ? wb_dat_i[7:0] : flags;
					exec_pkg::OFF_WREG: next_wreg = wb_sel_i[0] ? wb_dat_i[7:0] : wreg;
					default: next_pc = pc;
				endcase
			end
		end
		if (state == exec_pkg::ST_RUN && cnt == cycles - 2'h1) begin
			next_pc = target_pc; // RULE_06
			next_flags = shift_flags; // RULE_11
			next_wreg = shift_value; // RULE_16
			if (int'(p_idx) < IO_COUNT) begin
				if (op == exec_pkg::OP_IO_BIT_SET) begin
					next_io_regs[p_idx][sel] = 1'b1; // RULE_14
				end else if (op == exec_pkg::OP_IO_BIT_CLEAR) begin
					next_io_regs[p_idx][sel] = 1'b0; // RULE_15
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc <= exec_pkg::PC_RESET[PC_W-1:0];
			flags <= exec_pkg::FLAGS_RESET;
			wreg <= exec_pkg::WREG_RESET;
			instr <= exec_pkg::INSTR_RESET;
		end else begin
			pc <= next_pc;
			flags <= next_flags;
			wreg <= next_wreg;
			instr <= next_instr;
		end
	end

	// I/O register bank, one flip-flop byte per register.
	generate
		for (genvar g = 0; g < IO_COUNT; g++) begin : g_io
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					io_regs[g] <= exec_pkg::IO_RESET;
				end else begin
					io_regs[g] <= next_io_regs[g];
				end
			end
		end
	endgenerate

	// Outputs straight from flip-flops.
	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;
	assign pc_o = pc;
	assign status_flags_o = flags;
	assign work_reg_o = wreg;
	assign busy_o = busy;

endmodule

// File: exec_chk.sv
`timescale 1ns/1ps
module exec_chk #(
	parameter int PC_W = 16
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Core state.
	input wire logic [PC_W-1:0] pc_o,
	input wire logic [7:0] status_flags_o,
	input wire logic [7:0] work_reg_o,
	input wire logic busy_o
);
	localparam int B = PC_W + 8;
	logic start;
	logic [B+20:0] q;
	logic [B+20:0] next_q;
	logic [4:0] op;
	logic [PC_W-1:0] nxt;
	logic [PC_W-1:0] tgt;
	logic brn, skp, iob, sft;

	// Snapshot of instruction, flags and PC on the edge a run is accepted.
	always_comb begin
		start = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_o
			&& wb_adr_i[7:2] == 6'h00 && wb_sel_i[0];
		next_q = start ? {wb_dat_i[20:0], status_flags_o, pc_o} : q;
	end
	always_ff @(posedge clk_i) begin
		q <= next_q;
	end

	// Decoded snapshot: operation class, fall-through PC and branch target.
	assign op = q[B +: 5];
	assign nxt = q[PC_W-1:0] + 1'b1;
	assign tgt = nxt + {{(PC_W-7){q[B+14]}}, q[B+8 +: 7]};
	assign brn = op >= 5'h01 && op <= 5'h14;
	assign skp = op == 5'h15 || op == 5'h16;
	assign iob = op == 5'h17 || op == 5'h18;
	assign sft = op >= 5'h19 && op <= 5'h1c;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_start_busy;
		start |=> busy_o;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("run not started");
	property p_branch_len;
		$rose(busy_o) && brn |-> ##1 (!busy_o or (busy_o ##1 !busy_o));
	endproperty
	a_branch_len: assert property (p_branch_len) else $error("branch length");
	property p_branch_pc;
		$fell(busy_o) && brn |-> pc_o == ($past(busy_o, 2) ? tgt : nxt);
	endproperty
	a_branch_pc: assert property (p_branch_pc) else $error("branch pc");
	property p_branch_flags;
		$fell(busy_o) && brn |-> status_flags_o == q[PC_W +: 8];
	endproperty
	a_branch_flags: assert property (p_branch_flags) else $error("branch flags");
	property p_skip_pc;
		$fell(busy_o) && skp |->
			pc_o == (!$past(busy_o, 2) ? nxt : q[B+20] ? nxt + 2'h2 : nxt + 1'b1);
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("skip pc");
	property p_skip_flags;
		$fell(busy_o) && skp |-> status_flags_o == q[PC_W +: 8];
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip flags");
	property p_io_len;
		$rose(busy_o) && iob |-> ##1 busy_o ##1 !busy_o;
	endproperty
	a_io_len: assert property (p_io_len) else $error("io bit length");
	property p_io_keep;
		$fell(busy_o) && iob |-> status_flags_o == q[PC_W +: 8] && pc_o == nxt;
	endproperty
	a_io_keep: assert property (p_io_keep) else $error("io bit flags");
	property p_shift_len;
		$rose(busy_o) && sft |-> ##1 !busy_o;
	endproperty
	a_shift_len: assert property (p_shift_len) else $error("shift length");
	property p_shift_flags;
		$fell(busy_o) && sft |-> status_flags_o[3] == (status_flags_o[2] ^ status_flags_o[0])
			&& status_flags_o[1] == (work_reg_o == 8'h00)
			&& status_flags_o[7:4] == q[PC_W+4 +: 4];
	endproperty
	a_shift_flags: assert property (p_shift_flags) else $error("shift flags");
endmodule

bind branch_bit_shift_exec exec_chk #(.PC_W(PC_W)) chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.pc_o(pc_o),
	.status_flags_o(status_flags_o),
	.work_reg_o(work_reg_o),
	.busy_o(busy_o)
);

// File: exec_pkg.sv
// Functional notes
// RULE_01: Generic set-flag branch jumps to PC+k+1 when the selected flag is one.
// RULE_02: Generic clear-flag branch jumps when flag is zero; one cycle untaken, two taken.
// RULE_03: Branch-on-equal jumps only when zero flag is set; flags unchanged.
// RULE_04: Branch-on-unequal jumps only when zero flag is clear.
// RULE_05: Carry-one and lower jump on carry one; carry-zero and same-or-higher on zero.
// RULE_06: Minus jumps on negative one, plus on negative zero, target PC+k+1.
// RULE_07: Signed ge jumps when N xor V is zero; signed lt when it is one.
// RULE_08: Half-carry branches jump on half-carry one or zero respectively.
// RULE_09: T-bit branches jump on T one or zero, one or two cycles.
// RULE_10: Overflow branches jump on overflow one or zero respectively.
// RULE_11: Interrupt branches test global enable; no conditional branch alters any flag.
// RULE_12: Skip-on-one advances PC by two or three when the I/O bit is one.
// RULE_13: Skip-on-zero skips when the I/O bit is zero; no flags affected.
// RULE_14: I/O bit set writes one to bit b only, two cycles, no flag change.
// RULE_15: I/O bit clear writes zero to bit b only, two cycles, no flag change.
// RULE_16: Logical left shift inserts zero at bit 0, updates Z C N V.
// RULE_17: Logical right shift inserts zero at bit 7, updates Z C N V.
// RULE_18: Rotate left loads bit 0 from carry, old bit 7 to carry.
// RULE_19: Rotate right loads bit 7 from carry, old bit 0 to carry.
`timescale 1ns/1ps
package exec_pkg;

	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_PC = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_WREG = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_IO_BASE = 8'h80;

	// Bit positions inside the status flags.
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// Field layout of the instruction register.
	localparam int INSTR_OP_LSB = 0;
	localparam int INSTR_SEL_LSB = 5;
	localparam int INSTR_K_LSB = 8;
	localparam int INSTR_K_W = 7;
	localparam int INSTR_P_LSB = 15;
	localparam int INSTR_TWO_BIT = 20;
	localparam int INSTR_W = 21;

	// Field layout of the status register.
	localparam int STAT_BUSY = 0;
	localparam int STAT_TAKEN = 1;
	localparam int STAT_CYC_LSB = 2;

	// Reset values.
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] WREG_RESET = 8'h00;
	localparam logic [7:0] IO_RESET = 8'h00;
	localparam logic [20:0] INSTR_RESET = 21'h00_0000;

	// Execution lengths in core cycles.
	localparam logic [1:0] CYC_BRANCH_NOT = 2'h1;
	localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
	localparam logic [1:0] CYC_SKIP_NONE = 2'h1;
	localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [1:0] CYC_IO_BIT = 2'h2;
	localparam logic [1:0] CYC_SHIFT = 2'h1;

	// Operations handled by this slice of the core.
	typedef enum logic [4:0] {
		OP_NONE = 5'b00000,
		OP_BRANCH_FLAG_SET = 5'b00001,
		OP_BRANCH_FLAG_CLEAR = 5'b00010,
		OP_BRANCH_ON_EQUAL = 5'b00011,
		OP_BRANCH_ON_UNEQUAL = 5'b00100,
		OP_BRANCH_CARRY_ONE = 5'b00101,
		OP_BRANCH_CARRY_ZERO = 5'b00110,
		OP_BRANCH_SAME_OR_HIGHER = 5'b00111,
		OP_BRANCH_LOWER = 5'b01000,
		OP_BRANCH_MINUS = 5'b01001,
		OP_BRANCH_PLUS = 5'b01010,
		OP_BRANCH_SIGNED_GE = 5'b01011,
		OP_BRANCH_SIGNED_LT = 5'b01100,
		OP_BRANCH_HALFCARRY_ONE = 5'b01101,
		OP_BRANCH_HALFCARRY_ZERO = 5'b01110,
		OP_BRANCH_TBIT_ONE = 5'b01111,
		OP_BRANCH_TBIT_ZERO = 5'b10000,
		OP_BRANCH_OVERFLOW_ONE = 5'b10001,
		OP_BRANCH_OVERFLOW_ZERO = 5'b10010,
		OP_BRANCH_IRQ_ENABLED = 5'b10011,
		OP_BRANCH_IRQ_DISABLED = 5'b10100,
		OP_SKIP_IO_BIT_ONE = 5'b10101,
		OP_SKIP_IO_BIT_ZERO = 5'b10110,
		OP_IO_BIT_SET = 5'b10111,
		OP_IO_BIT_CLEAR = 5'b11000,
		OP_SHIFT_LEFT_LOGICAL = 5'b11001,
		OP_SHIFT_RIGHT_LOGICAL = 5'b11010,
		OP_ROTATE_LEFT_CARRY = 5'b11011,
		OP_ROTATE_RIGHT_CARRY = 5'b11100
	} op_t;

	// Execution sequencer states.
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} state_t;

endpackage

module branch_cond_eval (
	// Operation and operands.
	input wire exec_pkg::op_t op_i,
	input wire logic [2:0] sel_i,
	// Machine state tested.
	input wire logic [7:0] flags_i,
	input wire logic io_bit_i,
	// Outcome.
	output logic take_o
);

	// Decides whether a branch jumps or a skip skips; other operations never take.
	always_comb begin
		case (op_i)
			exec_pkg::OP_BRANCH_FLAG_SET: take_o = flags_i[sel_i]; // RULE_01
			exec_pkg::OP_BRANCH_FLAG_CLEAR: take_o = ~flags_i[sel_i]; // RULE_02
			exec_pkg::OP_BRANCH_ON_EQUAL: take_o = flags_i[exec_pkg::FLAG_Z]; // RULE_03
			exec_pkg::OP_BRANCH_ON_UNEQUAL: take_o = ~flags_i[exec_pkg::FLAG_Z]; // RULE_04
			exec_pkg::OP_BRANCH_CARRY_ONE,
			exec_pkg::OP_BRANCH_LOWER: take_o = flags_i[exec_pkg::FLAG_C]; // RULE_05
			exec_pkg::OP_BRANCH_CARRY_ZERO,
			exec_pkg::OP_BRANCH_SAME_OR_HIGHER: take_o = ~flags_i[exec_pkg::FLAG_C]; // RULE_05
			exec_pkg::OP_BRANCH_MINUS: take_o = flags_i[exec_pkg::FLAG_N]; // RULE_06
			exec_pkg::OP_BRANCH_PLUS: take_o = ~flags_i[exec_pkg::FLAG_N]; // RULE_06
			exec_pkg::OP_BRANCH_SIGNED_GE: begin
				take_o = ~(flags_i[exec_pkg::FLAG_N] ^ flags_i[exec_pkg::FLAG_V]); // RULE_07
			end
			exec_pkg::OP_BRANCH_SIGNED_LT: begin
				take_o = flags_i[exec_pkg::FLAG_N] ^ flags_i[exec_pkg::FLAG_V]; // RULE_07
			end
			exec_pkg::OP_BRANCH_HALFCARRY_ONE: take_o = flags_i[exec_pkg::FLAG_H]; // RULE_08
			exec_pkg::OP_BRANCH_HALFCARRY_ZERO: take_o = ~flags_i[exec_pkg::FLAG_H]; // RULE_08
			exec_pkg::OP_BRANCH_TBIT_ONE: take_o = flags_i[exec_pkg::FLAG_T]; // RULE_09
			exec_pkg::OP_BRANCH_TBIT_ZERO: take_o = ~flags_i[exec_pkg::FLAG_T]; // RULE_09
			exec_pkg::OP_BRANCH_OVERFLOW_ONE: take_o = flags_i[exec_pkg::FLAG_V]; // RULE_10
			exec_pkg::OP_BRANCH_OVERFLOW_ZERO: take_o = ~flags_i[exec_pkg::FLAG_V]; // RULE_10
			exec_pkg::OP_BRANCH_IRQ_ENABLED: take_o = flags_i[exec_pkg::FLAG_I]; // RULE_11
			exec_pkg::OP_BRANCH_IRQ_DISABLED: take_o = ~flags_i[exec_pkg::FLAG_I]; // RULE_11
			exec_pkg::OP_SKIP_IO_BIT_ONE: take_o = io_bit_i; // RULE_12
			exec_pkg::OP_SKIP_IO_BIT_ZERO: take_o = ~io_bit_i; // RULE_13
			default: take_o = 1'b0;
		endcase
	end

endmodule

// File: fetch_model.sv
`timescale 1ns/1ps
module fetch_model (
	// Clock.
	input wire logic clk_i,
	// Bus answer.
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	// Bus request.
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	// Bus idles from time zero.
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'hf;
		dat_o = 32'h0000_0000;
	end

	// One classic cycle; the request holds until ack is sampled high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
	endtask
endmodule

// File: shift_unit.sv
`timescale 1ns/1ps
module shift_unit (
	// Operation and operands.
	input wire exec_pkg::op_t op_i,
	input wire logic [7:0] value_i,
	input wire logic [7:0] flags_i,
	// Results; non-shift operations pass value and flags through.
	output logic [7:0] value_o,
	output logic [7:0] flags_o
);

	logic carry;

	// Forms the shifted byte and the bit pushed out into carry.
	always_comb begin
		value_o = value_i;
		carry = flags_i[exec_pkg::FLAG_C];
		flags_o = flags_i;
		case (op_i)
			exec_pkg::OP_SHIFT_LEFT_LOGICAL: begin
				value_o = {value_i[6:0], 1'b0}; // RULE_16
				carry = value_i[7];
			end
			exec_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
				value_o = {1'b0, value_i[7:1]}; // RULE_17
				carry = value_i[0];
			end
			exec_pkg::OP_ROTATE_LEFT_CARRY: begin
				value_o = {value_i[6:0], flags_i[exec_pkg::FLAG_C]}; // RULE_18
				carry = value_i[7];
			end
			exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
				value_o = {flags_i[exec_pkg::FLAG_C], value_i[7:1]}; // RULE_19
				carry = value_i[0];
			end
			default: begin
				value_o = value_i;
				carry = flags_i[exec_pkg::FLAG_C];
			end
		endcase
		// Only Z, C, N and V change; the overflow flag is N xor C after a shift.
		flags_o[exec_pkg::FLAG_C] = carry; // RULE_16
		flags_o[exec_pkg::FLAG_Z] = (value_o == 8'h00); // RULE_17
		flags_o[exec_pkg::FLAG_N] = value_o[7]; // RULE_18
		flags_o[exec_pkg::FLAG_V] = value_o[7] ^ carry; // RULE_19
		if (op_i != exec_pkg::OP_SHIFT_LEFT_LOGICAL && op_i != exec_pkg::OP_SHIFT_RIGHT_LOGICAL &&
			op_i != exec_pkg::OP_ROTATE_LEFT_CARRY && op_i != exec_pkg::OP_ROTATE_RIGHT_CARRY) begin
			flags_o = flags_i;
		end
	end

endmodule

// File: tb_branch_bit_shift_exec.sv
`timescale 1ns/1ps
module tb_branch_bit_shift_exec;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, busy, t, c, co;
	logic [3:0] sel;
	logic [6:0] kk;
	logic [7:0] adr, flg, wr, r, m;
	logic [15:0] pc, ep;
	logic [31:0] dw, dr, rd;
	logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
	int op;
	int fail_count = 0;
	int checks = 0;
	int ticks = 0;

	// Core clock and the design with its bus master.
	always #20 clk_i = ~clk_i;
	branch_bit_shift_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .pc_o(pc), .status_flags_o(flg), .work_reg_o(wr), .busy_o(busy));
	fetch_model fm (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));

	task automatic close_out();
		if (fail_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Loads flags, working register and PC 0x100, runs one instruction, reads status.
	task automatic run(input logic [4:0] o, input logic [2:0] s, input logic [6:0] k,
		input logic [4:0] p, input logic two, input logic [7:0] f, input logic [7:0] w);
		fm.xfer(1'b1, exec_pkg::OFF_FLAGS, {24'h00_0000, f}, rd);
		fm.xfer(1'b1, exec_pkg::OFF_WREG, {24'h00_0000, w}, rd);
		fm.xfer(1'b1, exec_pkg::OFF_PC, 32'h0000_0100, rd);
		fm.xfer(1'b1, exec_pkg::OFF_INSTR, {11'h000, two, p, k, s, o}, rd);
		do @(posedge clk_i); while (busy !== 1'b0);
		fm.xfer(1'b0, exec_pkg::OFF_STATUS, 32'h0000_0000, rd);
	endtask

	// Expected branch decision for each branch operation code.
	function automatic logic cond(input int o, input logic [2:0] s, input logic [7:0] f);
		case (o)
			1: return f[s];
			2: return !f[s];
			3: return f[1];
			4: return !f[1];
			5, 8: return f[0];
			6, 7: return !f[0];
			9: return f[2];
			10: return !f[2];
			11: return !(f[2] ^ f[3]);
			12: return f[2] ^ f[3];
			13: return f[5];
			14: return !f[5];
			15: return f[6];
			16: return !f[6];
			17: return f[3];
			18: return !f[3];
			19: return f[7];
			default: return !f[7];
		endcase
	endfunction

	// A hang ends the run as a mismatch.
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		cmp("reset", 32'h0000_0000, {pc, flg, wr});
		fm.xfer(1'b0, 8'h40, 32'h0000_0000, rd);
		cmp("unmapped", 32'h0000_0000, rd);
		// Every branch against four flag patterns, forward and backward offsets.
		for (int o = 1; o <= 20; o++) begin
			for (int i = 0; i < 4; i++) begin
				t = cond(o, 3'(o + i), pat[i]);
				kk = i[0] ? 7'h40 : 7'h05;
				run(5'(o), 3'(o + i), kk, 5'h00, 1'b0, pat[i], 8'h3c);
				ep = 16'h0101 + (t ? {{9{kk[6]}}, kk} : 16'h0000);
				cmp("pc", ep, pc);
				cmp("cycles", t ? 32'h2 : 32'h1, rd[3:2]);
				cmp("flags", pat[i], flg);
			end
		end
		// Skips on one and zero, one- and two-word followers, top I/O index first.
		for (int i = 0; i < 16; i++) begin
			fm.xfer(1'b1, 8'(252 - 4 * i), {24'h00_0000, pat[i % 4]}, rd);
			t = pat[i % 4][i % 8] ^ (i >= 8);
			run(i < 8 ? 5'h15 : 5'h16, 3'(i), 7'h00, 5'(31 - i), i[0], 8'h5a, 8'h00);
			ep = 16'h0101 + (t ? 16'h0001 + i[0] : 16'h0000);
			cmp("pc", ep, pc);
			cmp("cycles", 1 + t + (t & i[0]), rd[3:2]);
			cmp("flags", 8'h5a, flg);
		end
		// Set then clear each bit of the last I/O register.
		for (int i = 0; i < 16; i++) begin
			m = 8'h01 << i[2:0];
			fm.xfer(1'b1, 8'hfc, 32'h0000_00a5, rd);
			run(i < 8 ? 5'h17 : 5'h18, i[2:0], 7'h00, 5'h1f, 1'b0, 8'h33, 8'h00);
			cmp("cycles", 32'h2, rd[3:2]);
			cmp("flags", 8'h33, flg);
			fm.xfer(1'b0, 8'hfc, 32'h0000_0000, rd);
			cmp("io", i < 8 ? 8'ha5 | m : 8'ha5 & ~m, rd);
		end
		// Shifts and rotates with both carry values.
		for (int i = 0; i < 32; i++) begin
			op = 25 + i % 4;
			c = i[2];
			case (op)
				25: {co, r} = {pat[i / 8], 1'b0};
				26: {r, co} = {1'b0, pat[i / 8]};
				27: {co, r} = {pat[i / 8], c};
				default: {r, co} = {c, pat[i / 8]};
			endcase
			run(5'(op), 3'h0, 7'h00, 5'h00, 1'b0, {7'h73, c}, pat[i / 8]);
			cmp("wreg", r, wr);
			cmp("flags", {4'he, r[7] ^ co, r[7], r == 8'h00, co}, flg);
			cmp("cycles", 32'h1, rd[3:2]);
		end
		close_out();
	end
endmodule
